// ==== hw/fcb_defines.svh ====
// constants of the command-behaviour configuration block: opcodes,
// register addresses, field positions, reset values and write masks.
// assumes a mode 0 serial link sampled by a 50 MHz system clock.
`ifndef FCB_DEFINES_SVH
`define FCB_DEFINES_SVH

`define FCB_OP_REG_READ 8'h65
`define FCB_OP_REG_WRITE 8'h71
`define FCB_OP_BURST_LEN 8'hc0
`define FCB_OP_PROGRAM 8'h02
`define FCB_OP_PARAM_ERASE 8'h20
`define FCB_OP_SECT_ERASE 8'hd8
`define FCB_OP_SECT_ERASE4 8'hdc
`define FCB_OP_BULK_ERASE 8'h60
`define FCB_OP_BULK_ERASE2 8'hc7
`define FCB_OP_STATUS_RESUME 8'h30
`define FCB_OP_LEGACY_RESET 8'hf0
`define FCB_OP_RESET_ENABLE 8'h66
`define FCB_OP_RESET 8'h99

`define FCB_ADR_CB_NV 24'h000004
`define FCB_ADR_CB_V 24'h800004
`define FCB_ADR_BW_NV 24'h000005
`define FCB_ADR_BW_V 24'h800005

`define FCB_BIT_BLANK 5
`define FCB_BIT_WRAP512 4
`define FCB_BIT_UNIFORM 3
`define FCB_BIT_RESUME30 2
`define FCB_BIT_BLOCK256 1
`define FCB_BIT_LEGACY_RST 0
`define FCB_BIT_WRAP_OFF 4

`define FCB_CB_NV_DEFAULT 8'h00
`define FCB_BW_NV_DEFAULT 8'h10
`define FCB_CB_NV_MASK 8'h3f
`define FCB_CB_V_MASK 8'h37
`define FCB_BW_MASK 8'hf3

`endif

// ==== hw/fcb_pkg.sv ====
// types of the command-behaviour configuration block.
// assumes nothing beyond the constants header.
package fcb_pkg;
    typedef enum logic [1:0] {
        PH_CMD = 2'b00,
        PH_ADDR = 2'b01,
        PH_DATA = 2'b11,
        PH_IGNORE = 2'b10
    } fcb_phase_e;

    typedef enum logic [1:0] {
        ER_IDLE = 2'b00,
        ER_CHECK = 2'b01,
        ER_BLANK = 2'b11
    } fcb_erase_state_e;

    typedef enum logic [1:0] {
        EK_PARAM4K = 2'b00,
        EK_SECTOR64K = 2'b01,
        EK_BLOCK256K = 2'b11,
        EK_BULK = 2'b10
    } fcb_erase_kind_e;
endpackage

// ==== hw/fcb_config_regs.sv ====
// serial command front end holding the command-behaviour and burst-wrap registers
// and steering erase, program-buffer, reset and 30h decode from them.
// assumes link pins are asynchronous to clk and the array core runs on clk.
`timescale 1ns/1ns
`include "fcb_defines.svh"
module fcb_config_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic csN,
    input wire logic sck,
    input wire logic si,
    input wire logic hwResetN,
    output logic so,
    output logic soOeN,
    input wire logic arrayEraseOk,
    input wire logic blankZeroFound,
    input wire logic blankReadDone,
    output logic blankReadReq,
    output logic eraseStart,
    output logic eraseSkip,
    output fcb_pkg::fcb_erase_kind_e eraseKind,
    output logic [23:0] eraseAddr,
    output logic progLoad,
    output logic [8:0] progBufAddr,
    output logic [7:0] progData,
    output logic clearStatus,
    output logic eraseResume,
    output logic softReset,
    output logic uniformMap,
    output logic burstWrapOn,
    output logic [1:0] burstWrapLen
);
    // pin synchronisers: csN, sck, si, hwResetN
    logic [3:0] pinMeta_reg;
    logic [3:0] pinSync_reg;
    logic sckPrev_reg;
    logic csPrev_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinMeta_reg <= 4'hd; // idle levels, sck low in mode 0
            pinSync_reg <= 4'hd;
            sckPrev_reg <= 1'b0;
            csPrev_reg <= 1'b1;
        end else if (ce) begin
            pinMeta_reg <= {hwResetN, si, sck, csN};
            pinSync_reg <= pinMeta_reg;
            sckPrev_reg <= pinSync_reg[1];
            csPrev_reg <= pinSync_reg[0];
        end
    end

    logic csLow, sckRise, sckFall, csRise, hwRst;
    assign csLow = ~pinSync_reg[0];
    assign sckRise = pinSync_reg[1] & ~sckPrev_reg;
    assign sckFall = ~pinSync_reg[1] & sckPrev_reg;
    assign csRise = pinSync_reg[0] & ~csPrev_reg;
    assign hwRst = ~pinSync_reg[3];

    fcb_pkg::fcb_phase_e phase_reg, phase_next;
    fcb_pkg::fcb_erase_state_e eState_reg, eState_next;
    fcb_pkg::fcb_erase_kind_e eKind_reg, eKind_next;
    logic [2:0] bitCnt_reg, bitCnt_next, outCnt_reg, outCnt_next;
    logic [1:0] addrBytes_reg, addrBytes_next;
    logic [7:0] rxByte_reg, rxByte_next, opcode_reg, opcode_next, wdata_reg, wdata_next;
    logic [23:0] addr_reg, addr_next, eAddr_reg, eAddr_next;
    logic dataSeen_reg, dataSeen_next, rstArmed_reg, rstArmed_next;
    logic loadPend_reg, loadPend_next, soOeN_reg, soOeN_next;
    logic [7:0] outShift_reg, outShift_next;
    logic [7:0] cbV_reg, cbV_next, bwV_reg, bwV_next, cbProg_reg, cbProg_next;
    logic [7:0] bwProg_reg, bwProg_next;
    logic eraseStart_reg, eraseStart_next, eraseSkip_reg, eraseSkip_next;
    logic progLoad_reg, progLoad_next;
    logic [8:0] progBufAddr_reg, progBufAddr_next, bufPtr_reg, bufPtr_next;
    logic [7:0] progData_reg, progData_next;
    logic clearStatus_reg, clearStatus_next, eraseResume_reg, eraseResume_next;
    logic softReset_reg, softReset_next;
    logic [7:0] cbNv, bwNv, cbView, newByte, readValue;

    // non-volatile values are default xor the bits burnt so far
    assign cbNv = `FCB_CB_NV_DEFAULT ^ cbProg_reg;
    assign bwNv = `FCB_BW_NV_DEFAULT ^ bwProg_reg;
    // reserved bits read zero, map bit follows its twin
    assign cbView = (cbV_reg & `FCB_CB_V_MASK)
        | (cbNv & (8'h01 << `FCB_BIT_UNIFORM));
    assign newByte = {rxByte_reg[6:0], pinSync_reg[2]};

    // register read mux; the address is never advanced, so reads never wrap
    always_comb begin
        unique case (addr_reg)
            `FCB_ADR_CB_NV: readValue = cbNv;
            `FCB_ADR_CB_V: readValue = cbView;
            `FCB_ADR_BW_NV: readValue = bwNv;
            `FCB_ADR_BW_V: readValue = bwV_reg;
            default: readValue = 8'h00;
        endcase
    end

    // next state of the command engine, registers and erase sequencer
    always_comb begin
        phase_next = phase_reg;
        eState_next = eState_reg;
        eKind_next = eKind_reg;
        bitCnt_next = bitCnt_reg;
        outCnt_next = outCnt_reg;
        addrBytes_next = addrBytes_reg;
        rxByte_next = rxByte_reg;
        opcode_next = opcode_reg;
        wdata_next = wdata_reg;
        addr_next = addr_reg;
        eAddr_next = eAddr_reg;
        dataSeen_next = dataSeen_reg;
        rstArmed_next = rstArmed_reg;
        loadPend_next = loadPend_reg;
        soOeN_next = soOeN_reg;
        outShift_next = outShift_reg;
        cbV_next = cbV_reg;
        bwV_next = bwV_reg;
        cbProg_next = cbProg_reg;
        bwProg_next = bwProg_reg;
        bufPtr_next = bufPtr_reg;
        progBufAddr_next = progBufAddr_reg;
        progData_next = progData_reg;
        eraseStart_next = 1'b0;
        eraseSkip_next = 1'b0;
        progLoad_next = 1'b0;
        clearStatus_next = 1'b0;
        eraseResume_next = 1'b0;
        softReset_next = 1'b0;

        // byte assembly on rising link edges
        if (!csLow) begin
            phase_next = fcb_pkg::PH_CMD;
            bitCnt_next = 3'h0;
            addrBytes_next = 2'h0;
            loadPend_next = 1'b0;
            outCnt_next = 3'h0;
            soOeN_next = 1'b1;
        end else if (sckRise) begin
            rxByte_next = newByte;
            bitCnt_next = bitCnt_reg + 3'h1;
            if (bitCnt_reg == 3'h7) begin
                unique case (phase_reg)
                    fcb_pkg::PH_CMD: begin
                        opcode_next = newByte;
                        dataSeen_next = 1'b0;
                        addrBytes_next = 2'h0;
                        unique case (newByte)
                            `FCB_OP_REG_READ, `FCB_OP_REG_WRITE, `FCB_OP_PROGRAM,
                            `FCB_OP_PARAM_ERASE, `FCB_OP_SECT_ERASE,
                            `FCB_OP_SECT_ERASE4: phase_next = fcb_pkg::PH_ADDR;
                            `FCB_OP_BURST_LEN: phase_next = fcb_pkg::PH_DATA;
                            default: phase_next = fcb_pkg::PH_IGNORE;
                        endcase
                    end
                    fcb_pkg::PH_ADDR: begin
                        addr_next = {addr_reg[15:0], newByte};
                        addrBytes_next = addrBytes_reg + 2'h1;
                        if (addrBytes_reg == 2'h2) begin
                            phase_next = fcb_pkg::PH_DATA;
                            loadPend_next = (opcode_reg == `FCB_OP_REG_READ);
                            bufPtr_next = {addr_reg[0] & cbV_reg[`FCB_BIT_WRAP512], newByte};
                        end
                    end
                    fcb_pkg::PH_DATA: begin
                        wdata_next = newByte;
                        dataSeen_next = 1'b1;
                        if (opcode_reg == `FCB_OP_PROGRAM) begin
                            progLoad_next = 1'b1;
                            progBufAddr_next = bufPtr_reg;
                            progData_next = newByte;
                            if (cbV_reg[`FCB_BIT_WRAP512]) begin
                                bufPtr_next = bufPtr_reg + 9'h001;
                            end else begin
                                bufPtr_next = {1'b0, bufPtr_reg[7:0] + 8'h01};
                            end
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end else if (sckFall && phase_reg == fcb_pkg::PH_DATA
                && opcode_reg == `FCB_OP_REG_READ) begin
            // read data leaves msb first; the same register repeats every byte
            if (loadPend_reg || outCnt_reg == 3'h7) begin
                outShift_next = readValue;
                outCnt_next = 3'h0;
                loadPend_next = 1'b0;
                soOeN_next = 1'b0;
            end else begin
                outShift_next = {outShift_reg[6:0], 1'b0};
                outCnt_next = outCnt_reg + 3'h1;
            end
        end

        // erase sequencer with optional blank check
        unique case (eState_reg)
            fcb_pkg::ER_CHECK: begin
                if (arrayEraseOk) begin
                    eState_next = fcb_pkg::ER_BLANK;
                end else begin
                    eraseStart_next = 1'b1;
                    eState_next = fcb_pkg::ER_IDLE;
                end
            end
            fcb_pkg::ER_BLANK: begin
                if (blankZeroFound) begin
                    eraseStart_next = 1'b1;
                    eState_next = fcb_pkg::ER_IDLE;
                end else if (blankReadDone) begin
                    eraseSkip_next = 1'b1;
                    eState_next = fcb_pkg::ER_IDLE;
                end
            end
            default: begin
            end
        endcase

        // commands take effect when chip select rises after a whole opcode
        if (csRise && phase_reg != fcb_pkg::PH_CMD) begin
            rstArmed_next = (opcode_reg == `FCB_OP_RESET_ENABLE);
            unique case (opcode_reg)
                `FCB_OP_RESET: softReset_next = rstArmed_reg;
                `FCB_OP_LEGACY_RESET: softReset_next = cbV_reg[`FCB_BIT_LEGACY_RST];
                `FCB_OP_STATUS_RESUME: begin
                    eraseResume_next = cbV_reg[`FCB_BIT_RESUME30];
                    clearStatus_next = ~cbV_reg[`FCB_BIT_RESUME30];
                end
                `FCB_OP_REG_WRITE: begin
                    if (dataSeen_reg) begin
                        unique case (addr_reg)
                            `FCB_ADR_CB_NV: cbProg_next = cbProg_reg
                                | ((wdata_reg ^ `FCB_CB_NV_DEFAULT) & `FCB_CB_NV_MASK);
                            `FCB_ADR_CB_V: cbV_next = wdata_reg & `FCB_CB_V_MASK;
                            `FCB_ADR_BW_NV: bwProg_next = bwProg_reg
                                | ((wdata_reg ^ `FCB_BW_NV_DEFAULT) & `FCB_BW_MASK);
                            `FCB_ADR_BW_V: bwV_next = wdata_reg & `FCB_BW_MASK;
                            default: begin
                            end
                        endcase
                    end
                end
                `FCB_OP_BURST_LEN: begin
                    if (dataSeen_reg) begin
                        bwV_next = wdata_reg & `FCB_BW_MASK;
                    end
                end
                `FCB_OP_PARAM_ERASE, `FCB_OP_SECT_ERASE, `FCB_OP_SECT_ERASE4,
                `FCB_OP_BULK_ERASE, `FCB_OP_BULK_ERASE2: begin
                    if (eState_reg == fcb_pkg::ER_IDLE
                            && !(opcode_reg == `FCB_OP_PARAM_ERASE
                            && cbNv[`FCB_BIT_UNIFORM])
                            && (phase_reg == fcb_pkg::PH_DATA
                            || opcode_reg == `FCB_OP_BULK_ERASE
                            || opcode_reg == `FCB_OP_BULK_ERASE2)) begin
                        eAddr_next = addr_reg;
                        if (opcode_reg == `FCB_OP_PARAM_ERASE) begin
                            eKind_next = fcb_pkg::EK_PARAM4K;
                        end else if (opcode_reg == `FCB_OP_SECT_ERASE
                                || opcode_reg == `FCB_OP_SECT_ERASE4) begin
                            eKind_next = cbV_reg[`FCB_BIT_BLOCK256]
                                ? fcb_pkg::EK_BLOCK256K : fcb_pkg::EK_SECTOR64K;
                        end else begin
                            eKind_next = fcb_pkg::EK_BULK;
                        end
                        if (cbV_reg[`FCB_BIT_BLANK]) begin
                            eState_next = fcb_pkg::ER_CHECK;
                        end else begin
                            eraseStart_next = 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // hardware or software reset reloads volatile copies from their twins
        if (hwRst || softReset_reg) begin
            cbV_next = cbNv & `FCB_CB_V_MASK;
            bwV_next = bwNv & `FCB_BW_MASK;
            eState_next = fcb_pkg::ER_IDLE;
            rstArmed_next = 1'b0;
        end
    end

    // state registers; power-on values equal the unprogrammed twins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_reg <= fcb_pkg::PH_CMD;
            eState_reg <= fcb_pkg::ER_IDLE;
            eKind_reg <= fcb_pkg::EK_SECTOR64K;
            bitCnt_reg <= 3'h0;
            outCnt_reg <= 3'h0;
            addrBytes_reg <= 2'h0;
            rxByte_reg <= 8'h00;
            opcode_reg <= 8'h00;
            wdata_reg <= 8'h00;
            addr_reg <= 24'h000000;
            eAddr_reg <= 24'h000000;
            dataSeen_reg <= 1'b0;
            rstArmed_reg <= 1'b0;
            loadPend_reg <= 1'b0;
            soOeN_reg <= 1'b1;
            outShift_reg <= 8'h00;
            cbV_reg <= `FCB_CB_NV_DEFAULT & `FCB_CB_V_MASK;
            bwV_reg <= `FCB_BW_NV_DEFAULT;
            cbProg_reg <= 8'h00;
            bwProg_reg <= 8'h00;
            bufPtr_reg <= 9'h000;
            progBufAddr_reg <= 9'h000;
            progData_reg <= 8'h00;
            eraseStart_reg <= 1'b0;
            eraseSkip_reg <= 1'b0;
            progLoad_reg <= 1'b0;
            clearStatus_reg <= 1'b0;
            eraseResume_reg <= 1'b0;
            softReset_reg <= 1'b0;
        end else if (ce) begin
            phase_reg <= phase_next;
            eState_reg <= eState_next;
            eKind_reg <= eKind_next;
            bitCnt_reg <= bitCnt_next;
            outCnt_reg <= outCnt_next;
            addrBytes_reg <= addrBytes_next;
            rxByte_reg <= rxByte_next;
            opcode_reg <= opcode_next;
            wdata_reg <= wdata_next;
            addr_reg <= addr_next;
            eAddr_reg <= eAddr_next;
            dataSeen_reg <= dataSeen_next;
            rstArmed_reg <= rstArmed_next;
            loadPend_reg <= loadPend_next;
            soOeN_reg <= soOeN_next;
            outShift_reg <= outShift_next;
            cbV_reg <= cbV_next;
            bwV_reg <= bwV_next;
            cbProg_reg <= cbProg_next;
            bwProg_reg <= bwProg_next;
            bufPtr_reg <= bufPtr_next;
            progBufAddr_reg <= progBufAddr_next;
            progData_reg <= progData_next;
            eraseStart_reg <= eraseStart_next;
            eraseSkip_reg <= eraseSkip_next;
            progLoad_reg <= progLoad_next;
            clearStatus_reg <= clearStatus_next;
            eraseResume_reg <= eraseResume_next;
            softReset_reg <= softReset_next;
        end
    end

    // outputs
    assign so = outShift_reg[7];
    assign soOeN = soOeN_reg;
    assign blankReadReq = (eState_reg == fcb_pkg::ER_BLANK);
    assign eraseStart = eraseStart_reg;
    assign eraseSkip = eraseSkip_reg;
    assign eraseKind = eKind_reg;
    assign eraseAddr = eAddr_reg;
    assign progLoad = progLoad_reg;
    assign progBufAddr = progBufAddr_reg;
    assign progData = progData_reg;
    assign clearStatus = clearStatus_reg;
    assign eraseResume = eraseResume_reg;
    assign softReset = softReset_reg;
    assign uniformMap = cbNv[`FCB_BIT_UNIFORM];
    assign burstWrapOn = ~bwV_reg[`FCB_BIT_WRAP_OFF]; // main array reads only
    assign burstWrapLen = bwV_reg[1:0];
endmodule // fcb_config_regs

// ==== sim/fcb_config_regs_chk.sv ====
// assertions on the ports of the command-behaviour front end.
// assumes one clk domain and a bind onto fcb_config_regs.
`timescale 1ns/1ns
module fcb_config_regs_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic csN,
    input wire logic soOeN,
    input wire logic blankZeroFound,
    input wire logic blankReadDone,
    input wire logic blankReadReq,
    input wire logic eraseStart,
    input wire logic eraseSkip,
    input wire logic clearStatus,
    input wire logic eraseResume,
    input wire logic softReset,
    input wire logic uniformMap
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // answers of the array core during a blank read
    sequence s_zero;
        blankReadReq && blankZeroFound;
    endsequence
    sequence s_done;
        blankReadReq && blankReadDone && !blankZeroFound;
    endsequence
    sequence s_wait;
        blankReadReq && !blankZeroFound && !blankReadDone;
    endsequence
    property p_zeroStarts;
        s_zero |=> eraseStart && !eraseSkip;
    endproperty
    a_zeroStarts: assert property (p_zeroStarts) else $error("no erase after zero");
    property p_blankSkips;
        s_done |=> eraseSkip && !eraseStart;
    endproperty
    a_blankSkips: assert property (p_blankSkips) else $error("no skip on blank");
    property p_reqHolds;
        s_wait |=> blankReadReq;
    endproperty
    a_reqHolds: assert property (p_reqHolds) else $error("blank read dropped");
    property p_skipCause;
        eraseSkip |-> $past(blankReadReq) && $past(blankReadDone);
    endproperty
    a_skipCause: assert property (p_skipCause) else $error("skip without blank read");
    property p_opcode30;
        clearStatus |-> !eraseResume;
    endproperty
    a_opcode30: assert property (p_opcode30) else $error("30h decoded twice");
    property p_resetPulse;
        softReset |=> !softReset [*2];
    endproperty
    a_resetPulse: assert property (p_resetPulse) else $error("reset pulse too long");
    property p_mapQuiet;
        $changed(uniformMap) |-> csN;
    endproperty
    a_mapQuiet: assert property (p_mapQuiet) else $error("map bit moved in frame");
    property p_oeSelected;
        !soOeN |-> !$past(csN, 8);
    endproperty
    a_oeSelected: assert property (p_oeSelected) else $error("so driven unselected");
endmodule // fcb_config_regs_chk

bind fcb_config_regs fcb_config_regs_chk chk (.clk(clk), .rst(rst), .csN(csN), .soOeN(soOeN),
    .blankZeroFound(blankZeroFound), .blankReadDone(blankReadDone),
    .blankReadReq(blankReadReq), .eraseStart(eraseStart), .eraseSkip(eraseSkip),
    .clearStatus(clearStatus), .eraseResume(eraseResume), .softReset(softReset),
    .uniformMap(uniformMap));

// ==== sim/fcb_spi_host.sv ====
// host model driving the serial link in mode 0.
// assumes its caller waits for each frame to end.
`timescale 1ns/1ns
module fcb_spi_host (
    input wire logic clk,
    output logic csN,
    output logic sck,
    output logic si,
    input wire logic so
);
    initial begin
        csN = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // data line toggles while unselected so no stale bit is seen
    always @(negedge clk) if (csN) si = ~si;
    // one frame msb first, half period 4 clk, so taken before each fall
    task automatic xfer(input logic [47:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        csN = 1'b0;
        for (int i = 0; i < n; i++) begin
            si = tx[47 - i];
            repeat (4) @(negedge clk);
            sck = 1'b1;
            repeat (4) @(negedge clk);
            rx = {rx[6:0], so};
            sck = 1'b0;
        end
        repeat (4) @(negedge clk);
        csN = 1'b1;
        repeat (12) @(negedge clk);
    endtask
endmodule // fcb_spi_host

// ==== sim/tb_fcb_config_regs.sv ====
// self-checking bench of the command-behaviour front end.
// assumes the host model drives the link and the bench plays the array core.
`timescale 1ns/1ns
`include "fcb_defines.svh"
module tb_fcb_config_regs;
    logic clk, rst, csN, sck, si, hwResetN, so, soOeN, okIn, zeroIn, doneIn, req;
    logic eStart, eSkip, pLoad, clrSt, eRes, sRst, uMap, bwOn;
    fcb_pkg::fcb_erase_kind_e kind;
    logic [23:0] eAddr;
    logic [8:0] pAddr;
    logic [7:0] pData, rx;
    logic [1:0] bwLen;
    logic [4:0] seen;
    logic [8:0] loads[$];
    int num_errors = 0;
    int compares = 0;
    int cyc = 0;
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    fcb_config_regs dut (.clk(clk), .rst(rst), .ce(1'b1), .csN(csN), .sck(sck), .si(si),
        .hwResetN(hwResetN), .so(so), .soOeN(soOeN), .arrayEraseOk(okIn),
        .blankZeroFound(zeroIn), .blankReadDone(doneIn), .blankReadReq(req),
        .eraseStart(eStart), .eraseSkip(eSkip), .eraseKind(kind), .eraseAddr(eAddr),
        .progLoad(pLoad), .progBufAddr(pAddr), .progData(pData), .clearStatus(clrSt),
        .eraseResume(eRes), .softReset(sRst), .uniformMap(uMap), .burstWrapOn(bwOn),
        .burstWrapLen(bwLen));
    fcb_spi_host host (.clk(clk), .csN(csN), .sck(sck), .si(si), .so(so));
    // pulse capture, buffer loads and run limit
    always @(posedge clk) begin
        seen <= seen | {sRst, eRes, clrSt, eSkip, eStart};
        if (pLoad) loads.push_back(pAddr);
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rdChk(input logic [23:0] a, input logic [7:0] exp);
        host.xfer({`FCB_OP_REG_READ, a, 16'h0}, 40, rx);
        chk("register read", {16'h0, exp}, {16'h0, rx});
    endtask
    task automatic wr(input logic [23:0] a, input logic [7:0] d);
        host.xfer({`FCB_OP_REG_WRITE, a, d, 8'h0}, 40, rx);
    endtask
    task automatic op(input logic [7:0] c, input logic [23:0] a, input int n);
        seen = 5'h0;
        loads.delete();
        host.xfer({c, a, 16'ha55a}, n, rx);
    endtask
    // array core answer to a blank read
    task automatic core(input logic zero);
        for (int i = 0; i < 40 && req !== 1'b1; i++) @(negedge clk);
        zeroIn = zero;
        doneIn = !zero;
        @(negedge clk);
        zeroIn = 1'b0;
        doneIn = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        hwResetN = 1'b1;
        okIn = 1'b1;
        zeroIn = 1'b0;
        doneIn = 1'b0;
        seen = 5'h0;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk("map and wrap", 24'h0, {20'h0, uMap, bwOn, bwLen});
        rdChk(`FCB_ADR_CB_V, 8'h00);
        rdChk(`FCB_ADR_BW_V, `FCB_BW_NV_DEFAULT);
        wr(`FCB_ADR_CB_V, 8'hf7);
        rdChk(`FCB_ADR_CB_V, 8'h37);
        $display("test registers done");
        // blank check on with 256 KB blocks
        op(`FCB_OP_SECT_ERASE, 24'h040000, 32);
        core(1'b0);
        chk("blank skip", {17'h0, fcb_pkg::EK_BLOCK256K, 5'h02}, {17'h0, kind, seen});
        chk("erase addr", 24'h040000, eAddr);
        op(`FCB_OP_SECT_ERASE4, 24'h080000, 32);
        core(1'b1);
        chk("zero start", 24'h1, {19'h0, seen});
        okIn = 1'b0;
        op(`FCB_OP_BULK_ERASE, 24'h0, 8);
        chk("bulk start", {17'h0, fcb_pkg::EK_BULK, 5'h01}, {17'h0, kind, seen});
        okIn = 1'b1;
        op(`FCB_OP_PARAM_ERASE, 24'h001000, 32);
        core(1'b0);
        chk("param skip", {17'h0, fcb_pkg::EK_PARAM4K, 5'h02}, {17'h0, kind, seen});
        op(`FCB_OP_PROGRAM, 24'h0000ff, 48);
        chk("512 loads", {6'h0, 9'h0ff, 9'h100}, {6'h0, loads[0], loads[1]});
        op(`FCB_OP_STATUS_RESUME, 24'h0, 8);
        chk("30h resume", 24'h08, {19'h0, seen});
        op(`FCB_OP_LEGACY_RESET, 24'h0, 8);
        chk("f0 reset", 24'h10, {19'h0, seen});
        rdChk(`FCB_ADR_CB_V, 8'h00);
        $display("test set bits done");
        // all behaviour bits cleared again
        op(`FCB_OP_SECT_ERASE, 24'h050000, 32);
        chk("plain erase", {17'h0, fcb_pkg::EK_SECTOR64K, 5'h01}, {17'h0, kind, seen});
        op(`FCB_OP_PROGRAM, 24'h0000ff, 48);
        chk("256 loads", {6'h0, 9'h0ff, 9'h000}, {6'h0, loads[0], loads[1]});
        chk("prog data", 24'h5a, {16'h0, pData});
        op(`FCB_OP_BULK_ERASE2, 24'h0, 8);
        chk("bulk c7", {17'h0, fcb_pkg::EK_BULK, 5'h01}, {17'h0, kind, seen});
        op(`FCB_OP_STATUS_RESUME, 24'h0, 8);
        chk("30h clear", 24'h04, {19'h0, seen});
        op(`FCB_OP_LEGACY_RESET, 24'h0, 8);
        chk("f0 ignored", 24'h0, {19'h0, seen});
        op(`FCB_OP_RESET, 24'h0, 8);
        chk("lone 99h", 24'h0, {19'h0, seen});
        op(`FCB_OP_RESET_ENABLE, 24'h0, 8);
        op(`FCB_OP_RESET, 24'h0, 8);
        chk("66h 99h", 24'h10, {19'h0, seen});
        $display("test cleared bits done");
        // burst wrap set by C0h then reloaded by the reset pin
        op(`FCB_OP_BURST_LEN, 24'h010000, 16);
        chk("burst set", 24'h5, {21'h0, bwOn, bwLen});
        rdChk(`FCB_ADR_BW_V, 8'h01);
        hwResetN = 1'b0;
        repeat (6) @(negedge clk);
        hwResetN = 1'b1;
        repeat (6) @(negedge clk);
        chk("burst reload", 24'h0, {21'h0, bwOn, bwLen});
        // map bit follows only its one-time twin
        wr(`FCB_ADR_CB_NV, 8'h08);
        chk("uniform map", 24'h1, {23'h0, uMap});
        rdChk(`FCB_ADR_CB_V, 8'h08);
        op(`FCB_OP_PARAM_ERASE, 24'h001000, 32);
        chk("param refused", 24'h0, {19'h0, seen});
        rdChk(`FCB_ADR_CB_NV, 8'h08);
        // one-time burst-wrap twin reloaded by the 66h 99h reset
        wr(`FCB_ADR_BW_NV, 8'h03);
        rdChk(`FCB_ADR_BW_NV, 8'h03);
        op(`FCB_OP_RESET_ENABLE, 24'h0, 8);
        op(`FCB_OP_RESET, 24'h0, 8);
        chk("burst soft reload", 24'h7, {21'h0, bwOn, bwLen});
        rdChk(`FCB_ADR_CB_V, 8'h08);
        $display("test map and burst done");
        test_done();
    end
endmodule // tb_fcb_config_regs
